//--- tb/rtc_event_source.sv
// Purpose: event side of the rtc flag block
// Assumes: pulses last one pclk cycle
// Notes: battery low is held as a level
module rtc_event_source (
   input wire logic pclk,
   output rtc_irq_pkg::rtc_events_t events
);
   import rtc_irq_pkg::*;
   logic low_r = 1'b0;
   initial events = '0;
   // one-cycle pulse, then quiet again
   task automatic pulse(input logic [6:0] m);
      @(posedge pclk);
      events <= {m[6:1], low_r};
      @(posedge pclk);
      events <= {6'h00, low_r};
   endtask
   // level kept until told otherwise
   task automatic low(input logic b);
      @(posedge pclk);
      low_r = b;
      events <= {6'h00, b};
   endtask
endmodule // rtc_event_source

//--- tb/test_rtc_interrupt_flag_control.sv
// Purpose: self-checking bench of the rtc flag block
// Assumes: pready comes within 20 cycles
// Notes: registers at four times their index
module test_rtc_interrupt_flag_control;
   timeunit 1ns;
   timeprecision 1ps;
   import rtc_irq_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [3:0] pstrb = '0, strb_v = 4'hf;
   logic pready, pslverr, rtc_irq, irq;
   logic [2:0] pm;
   rtc_events_t ev;
   int n_errors = 0, comparisons = 0;
   // 4 ns period
   always #2 pclk = ~pclk;
   rtc_event_source src (.pclk(pclk), .events(ev));
   rtc_interrupt_flag_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .events(ev), .power_management_select(pm), .rtc_irq(rtc_irq), .irq(irq));
   task automatic wrap_up();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(string s, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // request held until the edge that sees pready
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
      output logic [31:0] r, output logic e);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= strb_v;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_errors++;
         wrap_up();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check("prdata", r, x);
   endtask
   // registered irq outputs settle two edges later
   task automatic w2();
      repeat (2) @(posedge pclk);
   endtask
   // --------------------------------------------
   // scenarios
   // --------------------------------------------
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rd(12'h004, 32'h0);
      rd(12'h008, 32'he0);
      check("pm", pm, 3'h7);
      apb(1'b0, 12'h020, 32'h0, r, e);
      check("pslverr", e, 1'b1);
   endtask
   task automatic t_watchdog();
      wr(12'h004, 32'h04);
      src.pulse(7'h40);
      w2();
      check("rtc_irq", rtc_irq, 1'b1);
      rd(12'h004, 32'h84);
      rd(12'h004, 32'h04);
      w2();
      check("rtc_irq", rtc_irq, 1'b0);
   endtask
   task automatic t_sticky();
      src.pulse(7'h3c);
      rd(12'h004, 32'h7c);
      check("rtc_irq", rtc_irq, 1'b0);
      wr(12'h004, 32'h7f);
      w2();
      check("rtc_irq", rtc_irq, 1'b1);
      rd(12'h004, 32'h7f);
      wr(12'h004, 32'h3b);
      rd(12'h004, 32'h3b);
      wr(12'h004, 32'h01);
      rd(12'h004, 32'h01);
      w2();
      check("rtc_irq", rtc_irq, 1'b0);
   endtask
   task automatic t_battery();
      src.pulse(7'h02);
      rd(12'h008, 32'he8);
      check("rtc_irq", rtc_irq, 1'b0);
      wr(12'h008, 32'hea);
      w2();
      check("rtc_irq", rtc_irq, 1'b1);
      wr(12'h008, 32'he2);
      rd(12'h008, 32'he2);
      check("rtc_irq", rtc_irq, 1'b0);
      src.low(1'b1);
      rd(12'h008, 32'he6);
      wr(12'h008, 32'he1);
      rd(12'h008, 32'he5);
      check("rtc_irq", rtc_irq, 1'b1);
      wr(12'h008, 32'h41);
      w2();
      check("pm", pm, 3'h2);
      src.low(1'b0);
      rd(12'h008, 32'h41);
   endtask
   task automatic t_status();
      wr(12'h010, 32'h7f);
      wr(12'h00c, 32'h7f);
      w2();
      check("irq", irq, 1'b0);
      src.pulse(7'h04);
      w2();
      check("irq", irq, 1'b1);
      wr(12'h00c, 32'h7f);
      wr(12'h010, 32'h0);
      src.pulse(7'h04);
      w2();
      check("irq", irq, 1'b0);
   endtask
   // byte 0 strobe low: write ignored
   task automatic t_strobe();
      strb_v = 4'he;
      wr(12'h004, 32'h07);
      strb_v = 4'hf;
      rd(12'h004, 32'h01);
   endtask
   // reset in mid-run brings back reset values
   task automatic t_midreset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h004, 32'h0);
      rd(12'h008, 32'he0);
      check("pm", pm, 3'h7);
      check("rtc_irq", rtc_irq, 1'b0);
      check("irq", irq, 1'b0);
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_watchdog();
      t_sticky();
      t_strobe();
      t_battery();
      t_status();
      t_midreset();
      wrap_up();
   end
endmodule // test_rtc_interrupt_flag_control

//--- verilog/rtc_interrupt_flag_control.sv
// Purpose: interrupt flag and enable registers of a real-time clock
// Assumes: event inputs are one-cycle pulses, battery low is a level
// Notes: APB slave, one cycle wait state on each access
// How it works
// - watchdog flag bit7, cleared by reading
// - countdown B event sets bit5
// - second tick sets bit4
// - sticky flags clear only on host zero-write
// - bit2 enables watchdog interrupt
// - bit1 countdown A, bit0 countdown B enables
// - event register resets to zero
// - power field bits7-5, resets to 111
// - switchover sets battery flag bit3
// - battery low flag mirrors level, read-only
// - bit1 enables switchover interrupt
// - bit0 enables battery low interrupt
// - battery flags, enables reset zero
// - unused bits read zero
//
// Chosen here: register access over APB.
`include "rtc_irq_defs.svh"
module rtc_interrupt_flag_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire rtc_irq_pkg::rtc_events_t events,
   output logic [2:0] power_management_select,
   output logic rtc_irq,
   output logic irq
);
   import rtc_irq_pkg::*;

   // ----------------------------------------
   // state and bus decode
   // ----------------------------------------
   logic [7:0] evt_r;
   logic [4:0] bat_r;
   logic [2:0] pm_r;
   logic [`NUM_EVT-1:0] ist_r, imask_r;
   acc_state_t st_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r, rtc_irq_r, irq_r;

   function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
      hit = (a[11:2] == {2'h0, idx}) && (a[1:0] == 2'h0);
   endfunction

   wire acc = psel && penable && (st_r == ACC_WAIT);
   wire wr = acc && pwrite && pstrb[0];
   wire rd = acc && !pwrite;
   wire sel_evt = hit(paddr, `IDX_EVT);
   wire sel_bat = hit(paddr, `IDX_BAT);
   wire sel_ist = hit(paddr, `IDX_IRQ_STAT);
   wire sel_msk = hit(paddr, `IDX_IRQ_MASK);
   wire mapped = sel_evt | sel_bat | sel_ist | sel_msk;
   wire [7:0] wd = pwdata[7:0];
   wire wr_evt = wr && sel_evt;
   wire wr_bat = wr && sel_bat;
   wire rd_evt = rd && sel_evt;

   // ----------------------------------------
   // event register: flags and timer enables
   // ----------------------------------------
   // sticky flags: host may only write zero; a same-cycle event wins
   wire [4:0] keep = wr_evt ? (evt_r[7:3] & {1'b1, wd[6:3]}) : evt_r[7:3];
   wire wda_keep = rd_evt ? 1'b0 : evt_r[`BIT_WDA_FLAG];
   wire [7:0] evt_nxt = {
      wda_keep | events.watchdog_a,
      keep[3] | events.countdown_a,
      keep[2] | events.countdown_b,
      keep[1] | events.second_tick,
      keep[0] | events.alarm,
      wr_evt ? wd[2:0] : evt_r[2:0]
   };
   // register reset to zero: every timer interrupt off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) evt_r <= `RST_EVT;
      else evt_r <= evt_nxt;
   end

   // ----------------------------------------
   // battery register
   // ----------------------------------------
   // bat_r = {switch flag, low flag, switch ie, low ie, spare}
   wire bsw_nxt = (bat_r[4] & ~(wr_bat & ~wd[`BIT_BSW_FLAG])) | events.battery_switch;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bat_r <= 5'h00;
         pm_r <= `RST_PM;
      end else begin
         bat_r[4] <= bsw_nxt;
         bat_r[3] <= events.battery_low_lvl;
         bat_r[2] <= wr_bat ? wd[`BIT_BSW_IE] : bat_r[2];
         bat_r[1] <= wr_bat ? wd[`BIT_BLO_IE] : bat_r[1];
         bat_r[0] <= 1'b0;
         pm_r <= wr_bat ? wd[`PM_HI:`PM_LO] : pm_r;
      end
   end
   wire [7:0] bat_view = {pm_r, 1'b0, bat_r[4:1]};

   // ----------------------------------------
   // device interrupt from flags and enables
   // ----------------------------------------
   // watchdog flag has no disable path into the enable of second/alarm here
   wire rtc_irq_nxt = (evt_nxt[`BIT_WDA_FLAG] & evt_nxt[`BIT_WDA_IE])
      | (evt_nxt[`BIT_CTA_FLAG] & evt_nxt[`BIT_CTA_IE])
      | (evt_nxt[`BIT_CTB_FLAG] & evt_nxt[`BIT_CTB_IE])
      | (bsw_nxt & (wr_bat ? wd[`BIT_BSW_IE] : bat_r[2]))
      | (events.battery_low_lvl & (wr_bat ? wd[`BIT_BLO_IE] : bat_r[1]));

   // ----------------------------------------
   // sticky bus status, mask, interrupt line
   // ----------------------------------------
   wire [`NUM_EVT-1:0] ev_vec = events;
   wire [`NUM_EVT-1:0] ist_clr = (wr && sel_ist) ? pwdata[`NUM_EVT-1:0] : '0;
   wire [`NUM_EVT-1:0] ist_nxt = (ist_r & ~ist_clr) | ev_vec; // set beats clear
   wire [`NUM_EVT-1:0] imask_nxt = (wr && sel_msk) ? pwdata[`NUM_EVT-1:0] : imask_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_r <= '0;
         imask_r <= '0;
         rtc_irq_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         ist_r <= ist_nxt;
         imask_r <= imask_nxt;
         rtc_irq_r <= rtc_irq_nxt;
         irq_r <= |(ist_nxt & imask_nxt);
      end
   end

   // ----------------------------------------
   // apb handshake and read data
   // ----------------------------------------
   // one wait cycle keeps pready registered
   wire [31:0] rd_mux = sel_evt ? {24'h0, evt_r} :
      sel_bat ? {24'h0, bat_view} :
      sel_ist ? {25'h0, ist_r} :
      sel_msk ? {25'h0, imask_r} : 32'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ACC_IDLE;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         case (st_r)
            ACC_IDLE: begin
               pready_r <= 1'b0;
               pslverr_r <= 1'b0;
               if (psel && penable) begin
                  st_r <= ACC_WAIT;
                  pready_r <= 1'b1;
                  pslverr_r <= !mapped;
                  prdata_r <= pwrite ? 32'h0 : rd_mux;
               end
            end
            ACC_WAIT: begin
               st_r <= ACC_IDLE;
               pready_r <= 1'b0;
               pslverr_r <= 1'b0;
            end
            default: st_r <= ACC_IDLE;
         endcase
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign rtc_irq = rtc_irq_r;
   assign irq = irq_r;
   assign power_management_select = pm_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_cta_set;
      events.countdown_a;
   endsequence
   AST_CTB_SET: assert property (events.countdown_b |=> evt_r[`BIT_CTB_FLAG])
      else $error("countdown b flag not set");
   AST_SEC_SET: assert property (events.second_tick |=> evt_r[`BIT_SEC_FLAG])
      else $error("second flag not set");
   AST_WDA_RDCLR: assert property (rd_evt && !events.watchdog_a |=> !evt_r[7])
      else $error("watchdog flag not cleared by read");
   AST_STICKY: assert property (s_cta_set ##1 !wr_evt |=> evt_r[`BIT_CTA_FLAG])
      else $error("countdown a flag lost");
   AST_BSW_SET: assert property (events.battery_switch |=> bat_r[4])
      else $error("switch flag not set");
   AST_BLO_LVL: assert property (##1 bat_r[3] == $past(events.battery_low_lvl))
      else $error("battery low flag wrong");
   AST_WDA_IE: assert property (evt_r[7] && evt_r[2] && !rd_evt && !wr_evt |=> rtc_irq_r)
      else $error("watchdog irq missing");
   AST_BSW_OFF: assert property (rtc_irq_r && !bat_r[2] && !bat_r[1] |->
      $past(|(evt_nxt[7:5] & evt_nxt[2:0])))
      else $error("irq without enabled flag");
   AST_PM_WR: assert property (wr_bat |=> pm_r == $past(wd[7:5]))
      else $error("power field not written");
   AST_ZERO: assert property (bat_view[4] == 1'b0)
      else $error("unused bit set");

   // ----------------------------------------
   // checks on flag setting and holding
   // ----------------------------------------
   // host zero-write with no competing event
   sequence s_cta_clr;
      wr_evt && !wd[6] && !events.countdown_a;
   endsequence

   // same for the battery switchover flag
   sequence s_bsw_clr;
      wr_bat && !wd[`BIT_BSW_FLAG] && !events.battery_switch;
   endsequence

   // watchdog event lands in bit 7
   AST_WDA_SET: assert property (events.watchdog_a |=> evt_r[7])
      else $error("watchdog flag not set");

   // countdown a event lands in bit 6
   AST_CTA_SET: assert property (s_cta_set |=> evt_r[6])
      else $error("countdown a flag not set");

   // alarm event lands in bit 3
   AST_ALM_SET: assert property (events.alarm |=> evt_r[3])
      else $error("alarm flag not set");

   // sticky without a host write
   AST_CTB_HOLD: assert property (evt_r[5] && !wr_evt |=> evt_r[5])
      else $error("countdown b flag lost");

   // second flag sticky without a write
   AST_SEC_HOLD: assert property (evt_r[4] && !wr_evt |=> evt_r[4])
      else $error("second flag lost");

   // alarm flag sticky without a write
   AST_ALM_HOLD: assert property (evt_r[3] && !wr_evt |=> evt_r[3])
      else $error("alarm flag lost");

   // only a read may clear the watchdog flag
   AST_WDA_HOLD: assert property (evt_r[7] && !rd_evt |=> evt_r[7])
      else $error("watchdog flag lost");

   // host writes never touch bit 7
   AST_WDA_RO: assert property (wr_evt && !events.watchdog_a |=> evt_r[7] == $past(evt_r[7]))
      else $error("watchdog flag written");

   // writing one keeps a set flag
   AST_CTA_KEEP: assert property (wr_evt && wd[6] && evt_r[6] |=> evt_r[6])
      else $error("countdown a flag dropped by one");

   // ----------------------------------------
   // checks on host clearing and enables
   // ----------------------------------------
   // zero-write clears countdown a
   AST_FLAG_CLR: assert property (s_cta_clr |=> !evt_r[6])
      else $error("countdown a flag not cleared");

   // zero-write clears countdown b
   AST_CTB_CLR: assert property (wr_evt && !wd[5] && !events.countdown_b |=> !evt_r[5])
      else $error("countdown b flag not cleared");

   // zero-write clears the second flag
   AST_SEC_CLR: assert property (wr_evt && !wd[4] && !events.second_tick |=> !evt_r[4])
      else $error("second flag not cleared");

   // zero-write clears the alarm flag
   AST_ALM_CLR: assert property (wr_evt && !wd[3] && !events.alarm |=> !evt_r[3])
      else $error("alarm flag not cleared");

   // zero-write clears the switchover flag
   AST_BSW_CLR: assert property (s_bsw_clr |=> !bat_r[4])
      else $error("switch flag not cleared");

   // switchover flag sticky without a write
   AST_BSW_HOLD: assert property (bat_r[4] && !wr_bat |=> bat_r[4])
      else $error("switch flag lost");

   // timer enables take the written value
   AST_IE_WR: assert property (wr_evt |=> evt_r[2:0] == $past(wd[2:0]))
      else $error("timer enables not written");

   // timer enables stay put otherwise
   AST_IE_HOLD: assert property (!wr_evt |=> $stable(evt_r[2:0]))
      else $error("timer enables changed");

   // battery enables take the written value
   AST_BIE_WR: assert property (wr_bat |=> bat_r[2:1] == $past(wd[1:0]))
      else $error("battery enables not written");

   // battery enables stay put otherwise
   AST_BIE_HOLD: assert property (!wr_bat |=> $stable(bat_r[2:1]))
      else $error("battery enables changed");

   // a write cannot force the low flag
   AST_BLO_RO: assert property (wr_bat |=> bat_r[3] == $past(events.battery_low_lvl))
      else $error("battery low flag written");

   // power field holds between writes
   AST_PM_HOLD: assert property (!wr_bat |=> $stable(pm_r))
      else $error("power field changed");

   // ----------------------------------------
   // checks on interrupt lines and bus
   // ----------------------------------------
   // enabled countdown a flag raises the line
   AST_CTA_IRQ: assert property (evt_r[6] && evt_r[1] && !wr_evt |=> rtc_irq_r)
      else $error("countdown a irq missing");

   // enabled countdown b flag raises the line
   AST_CTB_IRQ: assert property (evt_r[5] && evt_r[0] && !wr_evt |=> rtc_irq_r)
      else $error("countdown b irq missing");

   // enabled switchover flag raises the line
   AST_BSW_IRQ: assert property (bat_r[4] && bat_r[2] && !wr_bat |=> rtc_irq_r)
      else $error("switch irq missing");

   // enabled low level raises the line
   AST_BLO_IRQ: assert property (events.battery_low_lvl && bat_r[1] && !wr_bat |=> rtc_irq_r)
      else $error("battery low irq missing");

   // nothing enabled and pending: line drops
   AST_IRQ_NONE: assert property (!(|(evt_r[7:5] & evt_r[2:0])) && !(bat_r[4] & bat_r[2])
      && !(|events) && !wr_evt && !wr_bat |=> !rtc_irq_r)
      else $error("irq without cause");

   // masked status line follows status and mask
   AST_MASK_IRQ: assert property ((|(ist_r & imask_r)) && !(wr && (sel_ist || sel_msk)) |=> irq_r)
      else $error("status irq missing");

   // upper read bits always zero
   AST_RDATA_HI: assert property (pready_r |-> prdata_r[31:8] == 24'h0)
      else $error("upper read bits set");

   // ready is a single-cycle pulse
   AST_PREADY_1: assert property (pready_r |=> !pready_r)
      else $error("pready longer than one cycle");

   // unmapped access answers with an error
   AST_ERR_UNMAP: assert property (psel && penable && st_r == ACC_IDLE && !mapped
      |=> pslverr_r && pready_r)
      else $error("unmapped access without error");
endmodule // rtc_interrupt_flag_control

//--- verilog/rtc_irq_defs.svh
// Purpose: offsets, field positions, reset values of the rtc flag block
// Assumes: byte addresses are four times the register index
// Notes: definitions only
`ifndef RTC_IRQ_DEFS_SVH
`define RTC_IRQ_DEFS_SVH
`define IDX_EVT 8'h01
`define IDX_BAT 8'h02
`define IDX_IRQ_STAT 8'h03
`define IDX_IRQ_MASK 8'h04
`define BIT_WDA_FLAG 7
`define BIT_CTA_FLAG 6
`define BIT_CTB_FLAG 5
`define BIT_SEC_FLAG 4
`define BIT_ALM_FLAG 3
`define BIT_WDA_IE 2
`define BIT_CTA_IE 1
`define BIT_CTB_IE 0
`define PM_HI 7
`define PM_LO 5
`define BIT_BSW_FLAG 3
`define BIT_BLO_FLAG 2
`define BIT_BSW_IE 1
`define BIT_BLO_IE 0
`define RST_EVT 8'h00
`define RST_PM 3'h7
`define NUM_EVT 7
`endif

//--- verilog/rtc_irq_pkg.sv
// Purpose: types of the rtc flag block
// Assumes: nothing
// Notes: event bundle carried as one packed struct
package rtc_irq_pkg;
   typedef struct packed {
      logic watchdog_a;
      logic countdown_a;
      logic countdown_b;
      logic second_tick;
      logic alarm;
      logic battery_switch;
      logic battery_low_lvl;
   } rtc_events_t;
   typedef enum logic [1:0] {ACC_IDLE, ACC_WAIT} acc_state_t;
endpackage
